// ### common/sabr_pkg.sv
package sabr_pkg;
  localparam logic [7:0] CMD_CLEAR       = 8'h03;
  localparam logic [7:0] CMD_READ_STATUS = 8'hD0;
  localparam logic [7:0] BLOCK_COUNT     = 8'h09;
  localparam logic [7:0] IDLE_BYTE       = 8'hFF;
  localparam logic [7:0] CRC_POLY        = 8'h07;
  localparam logic [7:0] CRC_INIT        = 8'h00;
  localparam logic [3:0] TX_PEC_IDX      = 4'h9;
  localparam logic [3:0] WR_CMD_PEC      = 4'h2;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] ADDR_PREFIX     = 4'h8;
  localparam logic [7:0] KNOWN_CMDS [21] = '{8'h01, 8'h03, 8'h21, 8'h40, 8'hD0, 8'hD2, 8'hD3,
    8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE0,
    8'hE1, 8'hE2};
  localparam int ST2_PEC       = 7;
  localparam int ST2_RESTART   = 6;
  localparam int ST2_INVALID   = 5;
  localparam int ST2_CAPACITY  = 4;
  localparam int ST2_ISOFAIL   = 3;
  localparam int ST2_RESTARTED = 2;
  localparam int ST2_RANGE     = 1;
  localparam int ST2_ENABLE    = 0;
  localparam int ST1_SPARE     = 7;
  localparam int ST1_ISOOK     = 6;
  localparam int AL2_DELIVERY  = 0;
  localparam int CUR_M         = 5;
  localparam int PD_LIMIT_A    = 10;
  localparam logic [8:0] PD_LIMIT_CNT = 9'(PD_LIMIT_A * CUR_M);

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_WAIT} sabr_state_e;

  function automatic logic [7:0] sabr_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction
endpackage

// ### common/sabr_status_if.sv
`timescale 1ns/100ps
interface sabr_status_if;
  logic       clearReq;
  logic       pecErr;
  logic       badCmd;
  logic [7:0] st2;
  logic [7:0] st1;
  logic [7:0] al2;
  logic [7:0] al1;
  modport engine (output clearReq, pecErr, badCmd, input st2, st1, al2, al1);
  modport regs   (input clearReq, pecErr, badCmd, output st2, st1, al2, al1);
endinterface

// ### src/sabr_status_regs.sv
`timescale 1ns/100ps
module sabr_status_regs
  import sabr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  sabr_status_if.regs     sif,
  input  wire logic       enablePin,
  input  wire logic       willRestart,
  input  wire logic       highLine,
  input  wire logic       isoFailPulse,
  input  wire logic       isoOkPulse,
  input  wire logic       restartedPulse,
  input  wire logic       dataOutOfRange,
  input  wire logic [5:0] unitFlags,
  input  wire logic [7:1] alarm2In,
  input  wire logic [7:0] alarm1In,
  input  wire logic [7:0] sourcedCur,
  input  wire logic [7:0] shareCur
);
  logic [2:0] enS_q;
  logic       enF_q;
  logic       pecF_q, invF_q, isoFailF_q, isoOkF_q, rstOkF_q;
  wire  logic [8:0] curDiff = (sourcedCur >= shareCur) ? {1'b0, sourcedCur - shareCur}
                                                       : {1'b0, shareCur - sourcedCur};
  wire  logic       pdFault = curDiff > PD_LIMIT_CNT;

  // Enable pin is asynchronous; accepted once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enS_q <= 3'h0;
      enF_q <= 1'b0;
    end else begin
      enS_q <= {enS_q[1:0], enablePin};
      if (enS_q[1] == enS_q[2]) enF_q <= enS_q[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pecF_q     <= 1'b0;
      invF_q     <= 1'b0;
      isoFailF_q <= 1'b0;
      isoOkF_q   <= 1'b0;
      rstOkF_q   <= 1'b0;
    end else begin
      pecF_q     <= sif.pecErr     | (pecF_q     & ~sif.clearReq);
      invF_q     <= sif.badCmd     | (invF_q     & ~sif.clearReq);
      isoFailF_q <= isoFailPulse   | (isoFailF_q & ~sif.clearReq);
      isoOkF_q   <= isoOkPulse     | (isoOkF_q   & ~sif.clearReq);
      rstOkF_q   <= restartedPulse | (rstOkF_q   & ~sif.clearReq);
    end
  end

  // Isolation failure never feeds the internal fault bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sif.st2 <= 8'h00;
      sif.st1 <= 8'h00;
      sif.al2 <= 8'h00;
      sif.al1 <= 8'h00;
    end else begin
      sif.st2 <= {pecF_q, willRestart, invF_q, highLine, isoFailF_q, rstOkF_q,
                  dataOutOfRange, enF_q};
      sif.st1 <= {1'b0, isoOkF_q, unitFlags};
      sif.al2 <= {alarm2In, pdFault};
      sif.al1 <= alarm1In;
    end
  end

  chk_pec_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    sif.pecErr |=> ##1 sif.st2[ST2_PEC]) else $error("check error flag not raised");
  chk_range_noclear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dataOutOfRange && sif.clearReq) |=> sif.st2[ST2_RANGE])
    else $error("range flag dropped by clear");
  chk_enable_mirror: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enS_q[2] == enS_q[1]) |=> ##1 (sif.st2[ST2_ENABLE] == $past(enS_q[2], 2)))
    else $error("enable bit does not follow pin");
  chk_spare_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sif.st1[ST1_SPARE]) else $error("spare bit set");
  chk_pd_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    (curDiff > PD_LIMIT_CNT) |=> sif.al2[AL2_DELIVERY]) else $error("delivery fault missed");
endmodule

// ### src/sabr_smbus_top.sv
`timescale 1ns/100ps
module sabr_smbus_top
  import sabr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             alertN,
  input  wire logic [2:0]  addrSel,
  input  wire logic        enablePin,
  input  wire logic        willRestart,
  input  wire logic        highLine,
  input  wire logic        isoFailPulse,
  input  wire logic        isoOkPulse,
  input  wire logic        restartedPulse,
  input  wire logic        dataOutOfRange,
  input  wire logic [5:0]  unitFlags,
  input  wire logic [7:1]  alarm2In,
  input  wire logic [7:0]  alarm1In,
  input  wire logic [15:0] voutData,
  input  wire logic [7:0]  ioutData,
  input  wire logic [7:0]  tempData,
  input  wire logic [7:0]  sourcedCur,
  input  wire logic [7:0]  shareCur
);
  import sabr_pkg::*;

  sabr_status_if sif ();

  sabr_state_e state_q;
  logic [2:0]  sclS_q, sdaS_q;
  logic        sclF_q, sdaF_q;
  logic [3:0]  bitCnt_q, wrCnt_q, txIdx_q;
  logic [7:0]  shift_q, cmd_q, crc_q;
  logic        haveCmd_q, inXfer_q, isAddr_q, goTx_q;
  logic        sdaOe_q, alertN_q;
  logic        clearReq_q, pecErr_q, badCmd_q;
  logic [7:0]  snap_q [8];

  // Line filters: second and third stage must agree before a level is taken
  wire logic sclNew  = (sclS_q[1] == sclS_q[2]) ? sclS_q[2] : sclF_q;
  wire logic sdaNew  = (sdaS_q[1] == sdaS_q[2]) ? sdaS_q[2] : sdaF_q;
  wire logic sclRise = sclNew & ~sclF_q;
  wire logic sclFall = ~sclNew & sclF_q;
  wire logic startDet = sclF_q & sclNew & sdaF_q & ~sdaNew;
  wire logic stopDet  = sclF_q & sclNew & ~sdaF_q & sdaNew;
  wire logic [6:0] ownAddr = {ADDR_PREFIX, addrSel};
  wire logic addrHit  = shift_q[7:1] == ownAddr;
  wire logic knownCmd = cmd_q inside {KNOWN_CMDS};
  // Read phase is only served after the command was written
  wire logic rdOk     = haveCmd_q && (cmd_q == CMD_READ_STATUS) && (wrCnt_q == 4'h1);
  wire logic byteDone = sclFall && (bitCnt_q == BITS_PER_BYTE);
  wire logic [3:0] selIdx = (state_q == S_ACK) ? 4'h0 : txIdx_q + 4'h1;
  wire logic crcOk    = crc_q == CRC_INIT;
  // Last address with the read bit marks a read transfer, never judged as a write
  wire logic wrEval   = stopDet && haveCmd_q && inXfer_q && !goTx_q;
  logic [7:0] txByte;

  // Block reply: count, snapshot bytes, check byte
  always_comb begin
    if (selIdx == 4'h0) txByte = BLOCK_COUNT;
    else if (selIdx == TX_PEC_IDX) txByte = crc_q;
    else if (selIdx < TX_PEC_IDX) txByte = snap_q[selIdx[2:0] - 3'h1];
    else txByte = IDLE_BYTE;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclS_q <= 3'h7;
      sdaS_q <= 3'h7;
      sclF_q <= 1'b1;
      sdaF_q <= 1'b1;
    end else begin
      sclS_q <= {sclS_q[1:0], sclIn};
      sdaS_q <= {sdaS_q[1:0], sdaIn};
      sclF_q <= sclNew;
      sdaF_q <= sdaNew;
    end
  end

  // Write-only transfers are judged at stop, so a bad check byte blocks the command
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clearReq_q <= 1'b0;
      pecErr_q   <= 1'b0;
      badCmd_q   <= 1'b0;
    end else begin
      pecErr_q   <= wrEval && (!crcOk || wrCnt_q < WR_CMD_PEC);
      // Clear only with a valid check byte
      clearReq_q <= wrEval && crcOk && cmd_q == CMD_CLEAR && wrCnt_q == WR_CMD_PEC;
      // Unknown code, on write stop or on read attempt
      badCmd_q   <= (wrEval && crcOk && wrCnt_q >= WR_CMD_PEC && !knownCmd) ||
                    (state_q == S_RX && byteDone && isAddr_q && addrHit && shift_q[0] &&
                     haveCmd_q && !knownCmd);
    end
  end

  assign sif.clearReq = clearReq_q;
  assign sif.pecErr   = pecErr_q;
  assign sif.badCmd   = badCmd_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q   <= S_IDLE;
      bitCnt_q  <= 4'h0;
      wrCnt_q   <= 4'h0;
      txIdx_q   <= 4'h0;
      shift_q   <= 8'h00;
      cmd_q     <= 8'h00;
      crc_q     <= CRC_INIT;
      haveCmd_q <= 1'b0;
      inXfer_q  <= 1'b0;
      isAddr_q  <= 1'b0;
      goTx_q    <= 1'b0;
      sdaOe_q   <= 1'b0;
    end else if (stopDet) begin
      state_q  <= S_IDLE;
      inXfer_q <= 1'b0;
      sdaOe_q  <= 1'b0;
    end else if (startDet) begin
      // Repeated start keeps the running check value
      if (!inXfer_q) begin
        crc_q     <= CRC_INIT;
        wrCnt_q   <= 4'h0;
        haveCmd_q <= 1'b0;
      end
      state_q  <= S_RX;
      bitCnt_q <= 4'h0;
      isAddr_q <= 1'b1;
      inXfer_q <= 1'b1;
      sdaOe_q  <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE, S_WAIT: sdaOe_q <= 1'b0;
        S_RX: begin
          if (sclRise) begin
            shift_q  <= {shift_q[6:0], sdaNew};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteDone) begin
            if (isAddr_q && (!addrHit || (shift_q[0] && !rdOk))) begin
              state_q <= S_WAIT;
              goTx_q  <= shift_q[0];
            end else begin
              // Address and data bytes feed the check value
              crc_q   <= sabr_crc8(crc_q, shift_q);
              sdaOe_q <= 1'b1;
              state_q <= S_ACK;
              goTx_q  <= isAddr_q && shift_q[0];
              if (!isAddr_q) begin
                if (!haveCmd_q) cmd_q <= shift_q;
                haveCmd_q <= 1'b1;
                if (wrCnt_q != 4'hF) wrCnt_q <= wrCnt_q + 4'h1;
              end
              isAddr_q <= 1'b0;
            end
          end
        end
        S_ACK: begin
          if (sclFall) begin
            bitCnt_q <= 4'h0;
            if (goTx_q) begin
              state_q <= S_TX;
              txIdx_q <= 4'h0;
              shift_q <= txByte;
              crc_q   <= sabr_crc8(crc_q, txByte);
              sdaOe_q <= ~txByte[7];
            end else begin
              state_q <= S_RX;
              sdaOe_q <= 1'b0;
            end
          end
        end
        S_TX: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteDone) begin
            sdaOe_q <= 1'b0;
            state_q <= S_MACK;
          end else if (sclFall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            sdaOe_q <= ~shift_q[6];
          end
        end
        S_MACK: begin
          // Master answer is sampled while clock was high
          if (sclFall) begin
            if (sdaF_q) begin
              state_q <= S_WAIT;
            end else begin
              state_q  <= S_TX;
              bitCnt_q <= 4'h0;
              txIdx_q  <= selIdx;
              shift_q  <= txByte;
              if (selIdx < TX_PEC_IDX) crc_q <= sabr_crc8(crc_q, txByte);
              sdaOe_q  <= ~txByte[7];
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Snapshot at read address so one frame is self-consistent
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) snap_q[i] <= 8'h00;
    end else if (state_q == S_RX && byteDone && isAddr_q && addrHit && shift_q[0] && rdOk) begin
      snap_q[0] <= sif.st2;
      snap_q[1] <= sif.st1;
      snap_q[2] <= sif.al2;
      snap_q[3] <= sif.al1;
      snap_q[4] <= voutData[7:0];
      snap_q[5] <= voutData[15:8];
      snap_q[6] <= ioutData;
      snap_q[7] <= tempData;
    end
  end

  // Alert follows the invalid command flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) alertN_q <= 1'b1;
    else alertN_q <= ~sif.st2[ST2_INVALID];
  end

  assign sdaOe  = sdaOe_q;
  assign sdaOut = 1'b0;
  assign alertN = alertN_q;

  sabr_status_regs u_regs (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .sif           (sif),
    .enablePin     (enablePin),
    .willRestart   (willRestart),
    .highLine      (highLine),
    .isoFailPulse  (isoFailPulse),
    .isoOkPulse    (isoOkPulse),
    .restartedPulse(restartedPulse),
    .dataOutOfRange(dataOutOfRange),
    .unitFlags     (unitFlags),
    .alarm2In      (alarm2In),
    .alarm1In      (alarm1In),
    .sourcedCur    (sourcedCur),
    .shareCur      (shareCur)
  );

  chk_count_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == S_ACK && goTx_q && sclFall && !startDet && !stopDet) |=>
    (shift_q == BLOCK_COUNT && txIdx_q == 4'h0)) else $error("count byte not first");
  chk_block_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == S_TX) |-> (cmd_q == CMD_READ_STATUS)) else $error("block reply without D0h");
  chk_lsb_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == S_MACK && sclFall && !sdaF_q && txIdx_q == 4'h4 && !stopDet) |=>
    (shift_q == snap_q[4])) else $error("voltage low byte out of order");
  chk_pec_last: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == S_MACK && sclFall && !sdaF_q && txIdx_q == 4'h8 && !stopDet) |=>
    (shift_q == $past(crc_q))) else $error("check byte not sent after temperature");
  chk_nack_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == S_MACK && sclFall && sdaF_q && !stopDet && !startDet) |=> !sdaOe_q [*2])
    else $error("line held after host not-acknowledge");
  chk_clear_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
    clearReq_q |-> ($past(crc_q) == CRC_INIT && $past(cmd_q) == CMD_CLEAR))
    else $error("clear executed with bad check byte");
  chk_alert_invalid: assert property (@(posedge core_clk) disable iff (!rst_n)
    badCmd_q |=> ##2 !alertN_q) else $error("alert missing after invalid command");
endmodule

// ### tb/sabr_host_model.sv
`timescale 1ns/100ps
module sabr_host_model (
  input  wire logic core_clk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaLow
);
  // Bus clock stands high between frames, data line left to its pull-up
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic waitClk(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Long low phase so the slave lets go of the line before the clock rises
  task automatic bitIo(input logic txBit, output logic rxBit);
    waitClk(1);
    sdaLow = ~txBit;
    waitClk(4);
    sclOut = 1'b1;
    waitClk(3);
    rxBit  = sdaWire;
    sclOut = 1'b0;
  endtask

  task automatic startCond();
    waitClk(1);
    sdaLow = 1'b0;
    waitClk(4);
    sclOut = 1'b1;
    waitClk(4);
    sdaLow = 1'b1;
    waitClk(4);
    sclOut = 1'b0;
  endtask

  task automatic stopCond();
    waitClk(1);
    sdaLow = 1'b1;
    waitClk(4);
    sclOut = 1'b1;
    waitClk(4);
    sdaLow = 1'b0;
    waitClk(16);
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], r);
    end
    bitIo(1'b1, r);
    ack = ~r;
  endtask

  task automatic recvByte(input logic ackIt, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      b[i] = r;
    end
    bitIo(~ackIt, r);
  endtask

  task automatic writeFrame(input logic [6:0] addr, input logic [7:0] cmd,
                            input logic corrupt, output logic acked);
    logic       a0, a1, a2;
    logic [7:0] pec;
    pec = crc8(crc8(8'h00, {addr, 1'b0}), cmd) ^ {7'h00, corrupt};
    startCond();
    sendByte({addr, 1'b0}, a0);
    sendByte(cmd, a1);
    sendByte(pec, a2);
    stopCond();
    acked = a0 & a1 & a2;
  endtask

  task automatic readFrame(input logic [6:0] addr, input logic [7:0] cmd,
                           output logic [7:0] rx [10], output logic acked);
    logic a0, a1, a2;
    startCond();
    sendByte({addr, 1'b0}, a0);
    sendByte(cmd, a1);
    startCond();
    sendByte({addr, 1'b1}, a2);
    for (int i = 0; i < 10; i++) begin
      recvByte(i < 9, rx[i]);
    end
    stopCond();
    acked = a0 & a1 & a2;
  endtask
endmodule

// ### tb/status_alarm_block_readback_tb.sv
`timescale 1ns/100ps
module status_alarm_block_readback_tb;
  import sabr_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h45;
  logic        core_clk, rst_n, sdaWire, sclOut, sdaLow, sdaOut, sdaOe, alertN, ack;
  logic        enablePin, willRestart, highLine, isoFailPulse, isoOkPulse, restartedPulse;
  logic        dataOutOfRange, pecF, invF, isoF, okF, rstF;
  logic [5:0]  unitFlags;
  logic [7:1]  alarm2In;
  logic [7:0]  alarm1In, ioutData, tempData, sourcedCur, shareCur;
  logic [15:0] voutData;
  int          bad_count, checked;

  assign sdaWire = ~sdaLow & (sdaOe ? sdaOut : 1'b1);

  sabr_smbus_top i_sabr_smbus_top (.core_clk(core_clk), .rst_n(rst_n), .sclIn(sclOut),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .alertN(alertN), .addrSel(3'h5),
    .enablePin(enablePin), .willRestart(willRestart), .highLine(highLine),
    .isoFailPulse(isoFailPulse), .isoOkPulse(isoOkPulse), .restartedPulse(restartedPulse),
    .dataOutOfRange(dataOutOfRange), .unitFlags(unitFlags), .alarm2In(alarm2In),
    .alarm1In(alarm1In), .voutData(voutData), .ioutData(ioutData), .tempData(tempData),
    .sourcedCur(sourcedCur), .shareCur(shareCur));

  sabr_host_model i_sabr_host_model (.core_clk(core_clk), .sdaWire(sdaWire),
    .sclOut(sclOut), .sdaLow(sdaLow));

  task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    chkByte(what, {7'h00, exp}, {7'h00, got});
  endtask

  // Header bytes first so one loop yields the expected check byte
  task automatic readCheck(input string what);
    logic [7:0] rx [10];
    logic [7:0] ex [13];
    logic [8:0] diff;
    logic       gotAck;
    diff = (sourcedCur > shareCur) ? 9'(sourcedCur - shareCur) : 9'(shareCur - sourcedCur);
    ex = '{{DEV_ADDR, 1'b0}, 8'hD0, {DEV_ADDR, 1'b1}, 8'h09,
      {pecF, willRestart, invF, highLine, isoF, rstF, dataOutOfRange, enablePin},
      {1'b0, okF, unitFlags}, {alarm2In, diff > 9'h032}, alarm1In,
      voutData[7:0], voutData[15:8], ioutData, tempData, 8'h00};
    for (int i = 0; i < 12; i++) begin
      ex[12] = i_sabr_host_model.crc8(ex[12], ex[i]);
    end
    i_sabr_host_model.readFrame(DEV_ADDR, 8'hD0, rx, gotAck);
    chkBit({what, " ack"}, 1'b1, gotAck);
    for (int i = 0; i < 10; i++) begin
      chkByte($sformatf("%s byte %0d", what, i), ex[i + 3], rx[i]);
    end
    $display("Test %s finished", what);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Full run is near 8000 cycles, so this only trips on a hang
  initial begin
    #1_000_000;
    bad_count++;
    close_out();
  end

  initial begin
    bad_count = 0;
    checked = 0;
    rst_n = 1'b0;
    {enablePin, willRestart, highLine} = 3'h3;
    {isoFailPulse, isoOkPulse, restartedPulse, dataOutOfRange} = 4'h0;
    {pecF, invF, isoF, okF, rstF} = 5'h00;
    unitFlags = 6'h0B;
    alarm2In = 7'h55;
    alarm1In = 8'hA3;
    voutData = 16'h4ED4;
    ioutData = 8'h3C;
    tempData = 8'h1F;
    sourcedCur = 8'h64;
    shareCur = 8'h32;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chkBit("alert after reset", 1'b1, alertN);
    readCheck("reset values");
    i_sabr_host_model.writeFrame(DEV_ADDR, 8'h55, 1'b0, ack);
    invF = 1'b1;
    chkBit("unknown command ack", 1'b1, ack);
    chkBit("alert on unknown", 1'b0, alertN);
    readCheck("unknown command");
    @(negedge core_clk);
    {enablePin, willRestart, highLine} = 3'h5;
    shareCur = 8'h31;
    i_sabr_host_model.writeFrame(DEV_ADDR, CMD_CLEAR, 1'b1, ack);
    pecF = 1'b1;
    chkBit("alert kept on bad check", 1'b0, alertN);
    readCheck("bad check byte");
    @(negedge core_clk);
    {isoFailPulse, isoOkPulse, restartedPulse, dataOutOfRange} = 4'hF;
    @(negedge core_clk);
    {isoFailPulse, isoOkPulse, restartedPulse} = 3'h0;
    {isoF, okF, rstF} = 3'h7;
    readCheck("sticky events");
    i_sabr_host_model.writeFrame(DEV_ADDR, CMD_CLEAR, 1'b0, ack);
    {pecF, invF, isoF, okF, rstF} = 5'h00;
    chkBit("clear ack", 1'b1, ack);
    chkBit("alert cleared", 1'b1, alertN);
    readCheck("clear flags");
    @(negedge core_clk);
    dataOutOfRange = 1'b0;
    readCheck("range restored");
    i_sabr_host_model.writeFrame(7'h46, 8'h55, 1'b0, ack);
    chkBit("foreign address ack", 1'b0, ack);
    readCheck("foreign address");
    close_out();
  end
endmodule
